// ---- design/hocs_cfg.svh ----
// constants of the harmonic overcurrent stage: sizes, settings limits, timing
`ifndef HOCS_CFG_SVH
`define HOCS_CFG_SVH

// sizes
`define HOCS_N_STAGE 4
`define HOCS_N_PH 3
`define HOCS_N_ORD 12
`define HOCS_LOG_DEPTH 12
`define HOCS_DIV_BITS 40

// per unit pickup, units of 0.01 x nominal
`define HOCS_PU_MIN 8'h05
`define HOCS_PU_MAX 8'hc8
`define HOCS_PU_DEF 8'h14
// relative pickup, units of 0.01 percent of fundamental
`define HOCS_REL_MIN 15'h01f4
`define HOCS_REL_MAX 15'h4e20
`define HOCS_REL_DEF 15'h07d0
// monitored order code (0 = 2nd harmonic) and mode defaults
`define HOCS_HARM_DEF 4'h0
`define HOCS_HARM_LAST 4'hb
`define HOCS_MODE_DEF 1'b0

// arithmetic scales
`define HOCS_PCT 40'h64
`define HOCS_HYST_PCT 40'h61
`define HOCS_REL_SCALE 32'h2710
`define HOCS_RATIO_ONE 24'h000064
`define HOCS_RATIO_MAX 24'h989680
`define HOCS_IDMT_DECAY 32'h00000064

// timing: program cycle time base and derived counts in program cycles
`define HOCS_TICK_MS 5
`define HOCS_PRE_TRIG_MS 20
`define HOCS_PRE_FAULT_MS 200
`define HOCS_OP_MAX_MS 1800000
`define HOCS_BLOCK_LEAD_MS 5
`define HOCS_PRE_TRIG_TICKS (`HOCS_PRE_TRIG_MS / `HOCS_TICK_MS)
`define HOCS_PRE_FAULT_TICKS (`HOCS_PRE_FAULT_MS / `HOCS_TICK_MS)
`define HOCS_OP_MAX_TICKS 19'((`HOCS_OP_MAX_MS) / (`HOCS_TICK_MS))

// timer defaults, in program cycles
`define HOCS_OP_DELAY_DEF 19'h00014
`define HOCS_IDMT_K_DEF 16'h0014
`define HOCS_REL_DELAY_DEF 16'h0000

`endif

// ---- design/hocs_pkg.sv ----
// types shared by the harmonic overcurrent stage and its divider
package hocs_pkg;

  // gray coded along normal -> start -> trip
  typedef enum logic [1:0] {
    HOCS_NORMAL = 2'h0,
    HOCS_START = 2'h1,
    HOCS_TRIP = 2'h3,
    HOCS_BLOCKED = 2'h2
  } hocs_state_t;

  // one stage's settings, loaded as a whole
  typedef struct packed {
    logic rel_mode;
    logic [3:0] harm_code;
    logic [7:0] per_unit_pickup_level;
    logic [14:0] relative_harmonic_ratio;
    logic op_idmt;
    logic rst_idmt;
    logic [18:0] op_delay;
    logic [15:0] idmt_k;
    logic [15:0] rel_delay;
    logic ev_on_en;
    logic ev_off_en;
  } hocs_set_t;

  // one fault log entry
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [1:0] ev_code;
    logic [2:0] phases;
    logic [15:0] cur_now;
    logic [15:0] cur_pre_trig;
    logic [15:0] cur_pre_fault;
    logic [19:0] remain;
    logic [2:0] group;
  } hocs_log_t;

endpackage : hocs_pkg

// ---- design/hocs_div_if.sv ----
// request and answer signals between the stage and the shared divider
`timescale 1ns/1ps
interface hocs_div_if;
  logic go;
  logic [39:0] num;
  logic [31:0] den;
  logic done;
  logic [23:0] quo;
  modport req (output go, output num, output den, input done, input quo);
  modport srv (input go, input num, input den, output done, output quo);
endinterface : hocs_div_if

// ---- design/hocs_div.sv ----
// shared restoring divider, one quotient bit per clock, saturating result
`timescale 1ns/1ps
`include "hocs_cfg.svh"
module hocs_div (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  hocs_div_if.srv dv
);
  import hocs_pkg::*;

  logic busy;
  logic [5:0] cnt;
  logic [31:0] rem;
  logic [31:0] dsr;
  logic [39:0] dvd;
  logic [39:0] quo_acc;
  logic [23:0] quo;
  logic done;
  wire [32:0] trial = {rem, dvd[39]};
  wire fits = trial >= {1'b0, dsr};
  wire [32:0] diff = trial - {1'b0, dsr};
  wire [39:0] next_quo = {quo_acc[38:0], fits};
  // a zero divisor yields all ones, which saturates like an overflow
  wire [23:0] sat_quo = ((|next_quo[39:24]) || (next_quo[23:0] > `HOCS_RATIO_MAX)) ?
                        `HOCS_RATIO_MAX : next_quo[23:0];

  assign dv.done = done;
  assign dv.quo = quo;

  ////////////////////////////////////////////////////////////////////////////
  // iteration; a go while busy is ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      rem <= 32'h0;
      dsr <= 32'h0;
      dvd <= 40'h0;
      quo_acc <= 40'h0;
      quo <= 24'h0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!busy && dv.go) begin
        busy <= 1'b1;
        cnt <= 6'(`HOCS_DIV_BITS);
        rem <= 32'h0;
        dsr <= dv.den;
        dvd <= dv.num;
        quo_acc <= 40'h0;
      end else if (busy) begin
        rem <= fits ? diff[31:0] : trial[31:0];
        dvd <= {dvd[38:0], 1'b0};
        quo_acc <= next_quo;
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quo <= sat_quo;
        end
      end
    end
  end

endmodule : hocs_div

// ---- design/hocs_harmonic_overcurrent_stage.sv ----
// four harmonic overcurrent stages with timers, events, counters and fault logs
// Operation
// - pickup when any phase exceeds setting
// - release below 97 percent of setting
// - per phase ratio each cycle, common setting
// - per unit setting 0.05..2.00, default 0.20
// - relative setting 5..200 percent, default 20
// - settings reload while running, no reset
// - condition normal, start, trip or blocked
// - live ratio 0.01 steps up to 100000
// - expected operating time, 5 ms steps
// - signed time remaining while timing
// - blocking sampled at each program cycle
// - pickup unblocked gives start and timing
// - pickup while blocked gives blocked only
// - blocking during start acts as release
// - definite and inverse trip and reset timing
// - timestamped on/off events, selectable storing
// - resettable start, trip, blocked counters
// - four independent stages with own events
// - rolling twelve entry log, millisecond stamps
// - log entry contents on each on event
// - per unit or relative comparison mode
// - selectable harmonic order, 2nd default
`timescale 1ns/1ps
`include "hocs_cfg.svh"
module hocs_harmonic_overcurrent_stage (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic cycle_tick,
  input wire logic [2:0][11:0][15:0] measured_magnitude,
  input wire logic [2:0][15:0] fund_mag,
  input wire logic [3:0] blk_in,
  input wire logic [2:0] group_sel,
  input wire logic [31:0] time_ms,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_stage,
  input wire hocs_pkg::hocs_set_t cfg_data,
  input wire logic [3:0] cnt_clr,
  input wire logic [1:0] log_rd_stage,
  input wire logic [3:0] log_rd_idx,
  output wire logic [3:0][1:0] cond,
  output wire logic [3:0] start_out,
  output wire logic [3:0] trip_out,
  output wire logic [3:0] blocked_out,
  output wire logic [3:0][2:0] fault_phases,
  output wire logic [3:0][2:0][23:0] live_pickup_ratio,
  output wire logic [3:0][18:0] exp_time,
  output wire logic [3:0][19:0] remain_time,
  output wire logic [3:0][2:0] ev_on,
  output wire logic [3:0][2:0] ev_off,
  output wire logic [31:0] ev_stamp,
  output wire logic [3:0][2:0][15:0] op_count,
  output wire hocs_pkg::hocs_log_t log_rd_data
);
  import hocs_pkg::*;

  localparam hocs_set_t SET_DEF = '{
    rel_mode: `HOCS_MODE_DEF,
    harm_code: `HOCS_HARM_DEF,
    per_unit_pickup_level: `HOCS_PU_DEF,
    relative_harmonic_ratio: `HOCS_REL_DEF,
    op_idmt: 1'b0,
    rst_idmt: 1'b0,
    op_delay: `HOCS_OP_DELAY_DEF,
    idmt_k: `HOCS_IDMT_K_DEF,
    rel_delay: `HOCS_REL_DELAY_DEF,
    ev_on_en: 1'b1,
    ev_off_en: 1'b1
  };

  // keep loaded settings inside the documented ranges
  function automatic hocs_set_t clamp_set(input hocs_set_t d);
    hocs_set_t r;
    r = d;
    if (d.per_unit_pickup_level < `HOCS_PU_MIN) r.per_unit_pickup_level = `HOCS_PU_MIN;
    if (d.per_unit_pickup_level > `HOCS_PU_MAX) r.per_unit_pickup_level = `HOCS_PU_MAX;
    if (d.relative_harmonic_ratio < `HOCS_REL_MIN) r.relative_harmonic_ratio = `HOCS_REL_MIN;
    if (d.relative_harmonic_ratio > `HOCS_REL_MAX) r.relative_harmonic_ratio = `HOCS_REL_MAX;
    if (d.harm_code > `HOCS_HARM_LAST) r.harm_code = `HOCS_HARM_DEF;
    return r;
  endfunction : clamp_set

  // largest of three magnitudes
  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction : max3

  ////////////////////////////////////////////////////////////////////////////
  // cross-stage views used by the divider sweep and the log readback
  logic [31:0] lhs_a [4][3];
  logic [31:0] rhs_a [4][3];
  logic [15:0] k_a [4];
  logic [18:0] opd_a [4];
  logic idmt_a [4];
  logic [23:0] rmax_a [4];
  hocs_log_t rd_word [4];
  logic [23:0] ratio [4][3];
  logic [18:0] expct [4];

  hocs_div_if div_bus ();

  hocs_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .dv(div_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // divider sweep: slot[3:2] is the stage, slot[1:0] 0..2 a phase ratio, 3 the time
  logic sweeping;
  logic [3:0] slot;
  logic go;
  wire [1:0] sw_s = slot[3:2];
  wire [1:0] sw_p = slot[1:0];
  wire sw_time = (sw_p == 2'h3);
  wire [23:0] excess = (rmax_a[sw_s] > `HOCS_RATIO_ONE) ? rmax_a[sw_s] - `HOCS_RATIO_ONE : 24'h0;
  // inverse time t = k / (M - 1), scaled so both sides carry 0.01 units
  assign div_bus.go = go;
  assign div_bus.num = sw_time ? 40'(k_a[sw_s]) * `HOCS_PCT : 40'(lhs_a[sw_s][sw_p]) * `HOCS_PCT;
  assign div_bus.den = sw_time ? 32'(excess) : rhs_a[sw_s][sw_p];
  wire [18:0] q_time = (div_bus.quo > 24'(`HOCS_OP_MAX_TICKS)) ? `HOCS_OP_MAX_TICKS :
                       div_bus.quo[18:0];
  wire [18:0] idmt_time = (q_time > opd_a[sw_s]) ? q_time : opd_a[sw_s];

  // sequence control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sweeping <= 1'b0;
      slot <= 4'h0;
      go <= 1'b0;
    end else if (ce) begin
      go <= 1'b0;
      if (cycle_tick) begin
        sweeping <= 1'b1;
        slot <= 4'h0;
        go <= 1'b1;
      end else if (sweeping && div_bus.done) begin
        sweeping <= (slot != 4'hf);
        slot <= slot + 4'h1;
        go <= (slot != 4'hf);
      end
    end
  end

  // results of each slot
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ratio <= '{default: 24'h0};
      expct <= '{default: 19'h0};
    end else if (ce && sweeping && div_bus.done && !cycle_tick) begin
      if (!sw_time) ratio[sw_s][sw_p] <= div_bus.quo;
      else expct[sw_s] <= idmt_a[sw_s] ? idmt_time : opd_a[sw_s];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one independent stage per index
  logic [31:0] stamp;
  assign ev_stamp = stamp;

  genvar s, p, f, h;
  generate
    for (s = 0; s < `HOCS_N_STAGE; s++) begin : g_stage
      hocs_set_t set;
      hocs_state_t state;
      hocs_state_t next_state;
      logic [2:0] pk;
      logic [2:0] next_pk;
      logic [18:0] elapsed;
      logic [18:0] next_el;
      logic [31:0] acc;
      logic [31:0] next_acc;
      logic [15:0] relcnt;
      logic [15:0] next_rc;
      logic [31:0] lhs_q [3];
      logic [31:0] rhs_q [3];
      logic [15:0] hist [`HOCS_PRE_FAULT_TICKS];
      logic [15:0] pre_fault;
      logic [2:0] flg;
      logic [2:0] on_r;
      logic [2:0] off_r;
      logic [15:0] cnt [3];
      logic [19:0] remain;
      hocs_log_t log_mem [`HOCS_LOG_DEPTH];
      logic [3:0] wr_ptr;
      wire [15:0] mag [3];

      // settings swap on the fly; timers and state are left as they are
      always_ff @(posedge clk_sys) begin
        if (rst) set <= SET_DEF;
        else if (ce && cfg_wr && cfg_stage == 2'(s)) set <= clamp_set(cfg_data);
      end

      for (p = 0; p < `HOCS_N_PH; p++) begin : g_ph
        wire [31:0] lhs;
        wire [31:0] rhs;
        wire pick;
        wire drop;
        assign mag[p] = measured_magnitude[p][set.harm_code];
        // relative mode cross-multiplies so no divide sits in the decision path
        assign lhs = set.rel_mode ? 32'(mag[p]) * `HOCS_REL_SCALE : 32'(mag[p]);
        assign rhs = set.rel_mode ? 32'(set.relative_harmonic_ratio) * 32'(fund_mag[p]) :
                     32'(set.per_unit_pickup_level);
        assign pick = lhs > rhs;
        assign drop = 40'(lhs) * `HOCS_PCT < 40'(rhs) * `HOCS_HYST_PCT;
        assign next_pk[p] = pk[p] ? !drop : pick;
        assign lhs_a[s][p] = lhs_q[p];
        assign rhs_a[s][p] = rhs_q[p];
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            lhs_q[p] <= 32'h0;
            rhs_q[p] <= 32'h0;
          end else if (ce && cycle_tick) begin
            lhs_q[p] <= lhs;
            rhs_q[p] <= rhs;
          end
        end
      end

      assign k_a[s] = set.idmt_k;
      assign opd_a[s] = set.op_delay;
      assign idmt_a[s] = set.op_idmt;
      assign rmax_a[s] = (ratio[s][0] > ratio[s][1]) ?
                         ((ratio[s][0] > ratio[s][2]) ? ratio[s][0] : ratio[s][2]) :
                         ((ratio[s][1] > ratio[s][2]) ? ratio[s][1] : ratio[s][2]);

      wire pk_any = |next_pk;
      wire blk = blk_in[s];
      wire [31:0] incr = (rmax_a[s] > `HOCS_RATIO_ONE) ? 32'(rmax_a[s] - `HOCS_RATIO_ONE) : 32'h0;
      wire [31:0] k100 = 32'(set.idmt_k) * 32'(`HOCS_PCT);
      wire [18:0] el_inc = elapsed + 19'h1;
      wire trip_ready = (el_inc >= set.op_delay) && (!set.op_idmt || acc + incr >= k100);

      // program cycle step of the stage state machine and its timers
      always_comb begin
        next_state = state;
        next_el = elapsed;
        next_acc = acc;
        next_rc = relcnt;
        if (cycle_tick) begin
          unique case (state)
            HOCS_NORMAL: begin
              if (pk_any) begin
                next_state = blk ? HOCS_BLOCKED : HOCS_START;
              end else if (set.rst_idmt) begin
                next_acc = (acc > `HOCS_IDMT_DECAY) ? acc - `HOCS_IDMT_DECAY : 32'h0;
                next_el = (elapsed != 19'h0) ? elapsed - 19'h1 : 19'h0;
              end else if (relcnt != 16'h0) begin
                next_rc = relcnt - 16'h1;
              end else begin
                next_el = 19'h0;
                next_acc = 32'h0;
              end
            end
            HOCS_START: begin
              if (!pk_any || blk) begin
                next_state = HOCS_NORMAL;
                next_rc = set.rel_delay;
              end else begin
                next_el = el_inc;
                next_acc = acc + incr;
                if (trip_ready) next_state = HOCS_TRIP;
              end
            end
            HOCS_TRIP: begin
              if (!pk_any) begin
                next_state = HOCS_NORMAL;
                next_rc = set.rel_delay;
              end
            end
            HOCS_BLOCKED: begin
              if (!pk_any) next_state = HOCS_NORMAL;
              else if (!blk) next_state = HOCS_START;
            end
          endcase
        end
      end

      // start stays up under trip so a trip never reads as a start release
      wire [2:0] next_flg = {next_state == HOCS_BLOCKED, next_state == HOCS_TRIP,
                             next_state == HOCS_START || next_state == HOCS_TRIP};
      wire [2:0] ev_rise = next_flg & ~flg;
      wire [2:0] ev_fall = flg & ~next_flg;
      wire [18:0] exp_now = set.op_idmt ? expct[s] : set.op_delay;
      wire [19:0] next_remain = {1'b0, exp_now} - {1'b0, next_el};

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          state <= HOCS_NORMAL;
          pk <= 3'h0;
          elapsed <= 19'h0;
          acc <= 32'h0;
          relcnt <= 16'h0;
          flg <= 3'h0;
          remain <= 20'h0;
        end else if (ce) begin
          state <= next_state;
          elapsed <= next_el;
          acc <= next_acc;
          relcnt <= next_rc;
          flg <= next_flg;
          if (cycle_tick) pk <= next_pk;
          remain <= (next_state == HOCS_START) ? next_remain : 20'h0;
        end
      end

      // event pulses, gated by the on/off storing choice
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          on_r <= 3'h0;
          off_r <= 3'h0;
        end else if (ce) begin
          on_r <= ev_rise & {3{set.ev_on_en}};
          off_r <= ev_fall & {3{set.ev_off_en}};
        end
      end

      // counters: an event in the clearing cycle still counts
      for (f = 0; f < 3; f++) begin : g_cnt
        always_ff @(posedge clk_sys) begin
          if (rst) cnt[f] <= 16'h0;
          else if (ce && cnt_clr[s]) cnt[f] <= {15'h0, ev_rise[f]};
          else if (ce && ev_rise[f]) cnt[f] <= cnt[f] + 16'h1;
        end
        assign op_count[s][f] = cnt[f];
      end

      // magnitude history, one entry per program cycle
      for (h = 0; h < `HOCS_PRE_FAULT_TICKS; h++) begin : g_hist
        always_ff @(posedge clk_sys) begin
          if (rst) hist[h] <= 16'h0;
          else if (ce && cycle_tick) hist[h] <= (h == 0) ? max3(mag[0], mag[1], mag[2]) :
                                                hist[(h == 0) ? 0 : h - 1];
        end
      end

      wire [15:0] pf_now = hist[`HOCS_PRE_FAULT_TICKS - 1];
      wire any_on = |ev_rise;
      hocs_log_t entry;
      always_comb begin
        entry.stamp_ms = time_ms;
        entry.ev_code = ev_rise[1] ? 2'h1 : (ev_rise[2] ? 2'h2 : 2'h0);
        entry.phases = next_pk;
        entry.cur_now = max3(mag[0], mag[1], mag[2]);
        entry.cur_pre_trig = hist[`HOCS_PRE_TRIG_TICKS - 1];
        entry.cur_pre_fault = ev_rise[0] ? pf_now : pre_fault;
        entry.remain = next_remain;
        entry.group = group_sel;
      end

      // ring log; oldest entry overwritten once full
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          log_mem <= '{default: '0};
          wr_ptr <= 4'h0;
          pre_fault <= 16'h0;
        end else if (ce && any_on) begin
          log_mem[wr_ptr] <= entry;
          wr_ptr <= (wr_ptr == 4'(`HOCS_LOG_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
          if (ev_rise[0]) pre_fault <= pf_now;
        end
      end

      assign rd_word[s] = (log_rd_idx < 4'(`HOCS_LOG_DEPTH)) ? log_mem[log_rd_idx] : '0;
      assign cond[s] = state;
      assign start_out[s] = flg[0];
      assign trip_out[s] = flg[1];
      assign blocked_out[s] = flg[2];
      assign fault_phases[s] = pk;
      assign ev_on[s] = on_r;
      assign ev_off[s] = off_r;
      assign remain_time[s] = remain;
      assign exp_time[s] = expct[s];
      for (p = 0; p < `HOCS_N_PH; p++) begin : g_ratio_out
        assign live_pickup_ratio[s][p] = ratio[s][p];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // event stamp and log readback
  hocs_log_t rd_q;
  assign log_rd_data = rd_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stamp <= 32'h0;
      rd_q <= '0;
    end else if (ce) begin
      stamp <= time_ms;
      rd_q <= rd_word[log_rd_stage];
    end
  end

endmodule : hocs_harmonic_overcurrent_stage

// ---- dv/hocs_front_model.sv ----
// measurement front end: program cycle strobe and millisecond stamp
`timescale 1ns/1ps
module hocs_front_model #(
  parameter int GAP = 720
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic cycle_tick = 1'h0,
  output logic [31:0] time_ms = 32'h0
);
  int cnt = 0;
  // strobe spaced past the divider sweep, time moves 5 ms per cycle
  always_ff @(posedge clk_sys) begin
    cnt <= (rst || cnt == GAP - 1) ? 0 : cnt + 1;
    cycle_tick <= !rst && cnt == GAP - 1;
    time_ms <= rst ? 32'h0 : time_ms + ((cnt == GAP - 1) ? 32'h5 : 32'h0);
  end
endmodule : hocs_front_model

// ---- dv/hocs_chk_assertions.sv ----
// checker on stage 0 of the harmonic overcurrent stage
`timescale 1ns/1ps
module hocs_chk
  import hocs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic cycle_tick,
  input wire logic [3:0] blk_in,
  input wire logic [3:0] cnt_clr,
  input wire logic [3:0][1:0] cond,
  input wire logic [3:0] start_out,
  input wire logic [3:0] trip_out,
  input wire logic [3:0] blocked_out,
  input wire logic [3:0][2:0] ev_on,
  input wire logic [3:0][2:0] ev_off,
  input wire logic [3:0][19:0] remain_time,
  input wire logic [3:0][2:0][15:0] op_count
);
  // program cycle strobe as the design takes it
  wire logic tk = ce && cycle_tick;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_flag: assert property (
    start_out[0] == (cond[0] inside {HOCS_START, HOCS_TRIP})) else $error("start flag off");
  a_other_flags: assert property (
    {trip_out[0], blocked_out[0]} == {cond[0] == HOCS_TRIP, cond[0] == HOCS_BLOCKED})
    else $error("trip or blocked flag off");
  a_cond_hold: assert property (!$past(tk) |-> $stable(cond[0]))
    else $error("condition moved between cycles");
  a_block_no_start: assert property (tk && blk_in[0] && !trip_out[0] |=> !start_out[0])
    else $error("start while blocked");
  a_block_drops: assert property (
    tk && blk_in[0] && cond[0] == HOCS_START |=> cond[0] inside {HOCS_NORMAL, HOCS_BLOCKED})
    else $error("start kept under blocking");
  a_trip_cause: assert property (
    $rose(trip_out[0]) |-> $past(tk) && $past(cond[0]) == HOCS_START && !$past(blk_in[0]))
    else $error("trip without timed start");
  a_start_event: assert property ($rose(start_out[0]) |-> ev_on[0][0])
    else $error("no start on event");
  a_start_off: assert property ($fell(start_out[0]) |-> ev_off[0][0])
    else $error("no start off event");
  a_event_pulse: assert property (|ev_on[0] |=> ev_on[0] == 3'h0)
    else $error("event longer than one cycle");
  a_start_count: assert property (
    ev_on[0][0] && !$past(cnt_clr[0]) |-> op_count[0][0] == $past(op_count[0][0]) + 16'h1)
    else $error("start count not stepped");
  a_remain_idle: assert property (cond[0] != HOCS_START |-> remain_time[0] == 20'h0)
    else $error("remaining time outside start");
endmodule : hocs_chk
bind hocs_harmonic_overcurrent_stage hocs_chk chk_u (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .cycle_tick(cycle_tick), .blk_in(blk_in), .cnt_clr(cnt_clr), .cond(cond),
  .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .ev_on(ev_on),
  .ev_off(ev_off),
  .remain_time(remain_time), .op_count(op_count));

// ---- dv/hocs_harmonic_overcurrent_stage_bench.sv ----
// bench: random stimulus against a reference model of stages 0 and 1
`timescale 1ns/1ps
`include "hocs_cfg.svh"
module hocs_harmonic_overcurrent_stage_bench;
  import hocs_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic cycle_tick;
  logic [31:0] time_ms;
  logic [2:0][11:0][15:0] mm = '0;
  logic [2:0][15:0] fund = '0;
  logic [3:0] blk = '0;
  logic [2:0] grp = '0;
  logic cfg_wr = 1'h0;
  logic [1:0] cfg_stage = '0;
  hocs_set_t cfg = '0;
  logic [3:0] clr = '0;
  logic [3:0][1:0] cond;
  logic [3:0][2:0][23:0] ratio;
  logic [3:0][2:0][15:0] cnt;
  logic [3:0][2:0] fph;
  logic [3:0][18:0] ext;
  hocs_log_t log_q;
  hocs_state_t st [2] = '{HOCS_NORMAL, HOCS_NORMAL};
  logic [2:0] pk [2] = '{3'h0, 3'h0};
  int el [2], n_dly [2], starts = 0, ev_n = 0, err_total = 0, checks = 0;
  logic [7:0] pu, pu_c;
  logic [14:0] rs;
  logic [3:0] hc = 4'h1;
  logic [1:0] slot0;
  logic [15:0] f, m0 [3];
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  hocs_front_model front_u (.clk_sys(clk_sys), .rst(rst), .cycle_tick(cycle_tick),
    .time_ms(time_ms));
  hocs_harmonic_overcurrent_stage dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'h1),
    .cycle_tick(cycle_tick), .measured_magnitude(mm), .fund_mag(fund), .blk_in(blk),
    .group_sel(grp), .time_ms(time_ms), .cfg_wr(cfg_wr), .cfg_stage(cfg_stage),
    .cfg_data(cfg), .cnt_clr(clr), .log_rd_stage(2'h0), .log_rd_idx(4'h0), .cond(cond),
    .start_out(), .trip_out(), .blocked_out(), .fault_phases(fph), .live_pickup_ratio(ratio),
    .exp_time(ext), .remain_time(), .ev_on(), .ev_off(), .ev_stamp(), .op_count(cnt),
    .log_rd_data(log_q));
  ////////////////////////////////////////////////////////////
  // pickup of one stage per phase, a picked phase holds down to 97 percent
  function automatic logic [2:0] pick(input int s, input logic [2:0] held);
    logic [63:0] a, b;
    pick = 3'h0;
    for (int p = 0; p < 3; p++) begin
      a = (s == 0) ? 64'(mm[p][0]) * 100 : 64'(mm[p][hc]) * 1000000;
      b = (s == 0) ? 64'(pu_c) * 100 : 64'(rs) * fund[p] * 100;
      if (a > b || (held[p] && a >= b / 100 * 97)) pick[p] = 1'h1;
    end
  endfunction : pick
  // one program cycle of the reference state machine, definite time
  task automatic step(input int s);
    hocs_state_t nx;
    pk[s] = pick(s, pk[s]);
    nx = !(|pk[s]) ? HOCS_NORMAL : st[s] == HOCS_TRIP ? HOCS_TRIP :
      st[s] != HOCS_START ? (blk[s] ? HOCS_BLOCKED : HOCS_START) :
      blk[s] ? HOCS_NORMAL : el[s] + 1 >= n_dly[s] ? HOCS_TRIP : HOCS_START;
    // the delay count survives a release until a tick without pickup
    el[s] = (st[s] == HOCS_START && nx != HOCS_NORMAL) ? el[s] + 1 :
      (st[s] == HOCS_NORMAL && !(|pk[s])) ? 0 : el[s];
    if (s == 0 && nx != st[s] && nx != HOCS_NORMAL) begin
      if (ev_n % 12 == 0) slot0 = (nx == HOCS_START) ? 2'h0 : (nx == HOCS_TRIP) ? 2'h1 : 2'h2;
      ev_n++;
      starts += (nx == HOCS_START);
    end
    st[s] = nx;
  endtask : step
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // bounded wait for the edge that takes a cycle strobe
  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!cycle_tick && n < 2000);
    if (n >= 2000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_tick
  // back to back setting loads for stage 0 (per unit) and 1 (relative)
  task automatic configure;
    hocs_set_t c;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      c = '0;
      c.rel_mode = s[0];
      c.harm_code = (s == 0) ? 4'h0 : hc;
      c.per_unit_pickup_level = pu;
      c.relative_harmonic_ratio = rs;
      c.op_delay = 19'(n_dly[s]);
      c.ev_on_en = 1'h1;
      c.ev_off_en = 1'h1;
      cfg <= c;
      cfg_stage <= 2'(s);
      cfg_wr <= 1'h1;
    end
    @(posedge clk_sys);
    cfg_wr <= 1'h0;
  endtask : configure
  initial begin
    void'($urandom(32'hfb297312));
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    clr <= 4'hf;
    @(posedge clk_sys);
    clr <= 4'h0;
    @(negedge clk_sys);
    check("reset cond", cond, '0);
    for (int t = 0; t < 40; t++) begin
      // new settings every ten cycles, clamp corners first
      if (t % 10 == 0) begin
        pu = (t == 0) ? 8'h03 : (t == 10) ? 8'hca : 8'($urandom_range(200, 5));
        pu_c = (pu < `HOCS_PU_MIN) ? `HOCS_PU_MIN : (pu > `HOCS_PU_MAX) ? `HOCS_PU_MAX : pu;
        rs = 15'($urandom_range(20000, 500));
        hc = 4'($urandom_range(11, 1));
        n_dly[0] = $urandom_range(4, 1);
        n_dly[1] = $urandom_range(4, 1);
        configure();
      end
      wait_tick();
      step(0);
      step(1);
      // fresh magnitudes with boundary values, held until the next strobe
      for (int p = 0; p < 3; p++) begin
        m0[p] = mm[p][0];
        f = 16'($urandom_range(16'h1000, 16'h0064));
        fund[p] <= f;
        mm[p][hc] <= 16'($urandom_range(f / 2, 0));
        case ($urandom_range(3, 0))
          0: mm[p][0] <= {8'h0, pu_c};
          1: mm[p][0] <= 16'((pu_c * 97 + 99) / 100);
          default: mm[p][0] <= 16'($urandom_range(2 * pu_c + 2, 0));
        endcase
      end
      blk <= 4'($urandom) & 4'($urandom); // changes a full cycle before use
      grp <= 3'($urandom);
      @(negedge clk_sys);
      check("cond", {cond[1], cond[0]}, {st[1], st[0]});
      check("phases", fph[0], pk[0]);
      repeat (700) @(posedge clk_sys);
      @(negedge clk_sys);
      for (int p = 0; p < 3; p++) check("ratio", ratio[0][p], m0[p] * 100 / pu_c);
      check("exp time", ext[0], n_dly[0]);
    end
    check("starts", cnt[0][0], 16'(starts));
    if (ev_n > 0) check("log event", log_q.ev_code, slot0);
    @(posedge clk_sys);
    clr <= 4'h1;
    @(posedge clk_sys);
    clr <= 4'h0;
    @(negedge clk_sys);
    check("cleared", cnt[0][0], 16'h0);
    stop_test();
  end
endmodule : hocs_harmonic_overcurrent_stage_bench
